// *** hdl/kii_pkg.sv ***
// Notes on behaviour
// - Level mode: valid edge raises key request
// - Level mode: request follows enabled active levels
// - Level mode: held level masks further edges
// - Flag mode: edge latches channel flag, requests
// - Flag mode: clearing flag drops request
// - Flag mode: one interrupt per valid edge
// - Remaining flag re-raises request one clock later
// - Active flagless input re-raises after last clear
// - Released flagless input gives no interrupt
// - Pending flag cleared by acknowledge or software
// - Polarity bit: 0 falling, 1 rising
// - Enable bit 1 detects, 0 ignores input
// - Flag write: 1 ignored, 0 clears
package kii_pkg;

  // ==========================================================
  // Register map (byte offsets)
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_ENABLE = 8'h04;
  localparam logic [7:0] OFS_FLAG = 8'h08;
  localparam logic [7:0] OFS_PEND = 8'h0C;
  localparam logic [7:0] OFS_MASK = 8'h10;
  localparam logic [7:0] OFS_LEVEL = 8'h14;

  // ==========================================================
  // Field positions
  localparam int MODE_BIT = 7;
  localparam int POL_BIT = 0;
  localparam int PEND_BIT = 0;
  localparam int MASK_BIT = 0;
  localparam int LVL_REQ_BIT = 16;

  // ==========================================================
  // Values after reset
  localparam logic CTRL_MODE_RST = 1'b0;
  localparam logic CTRL_POL_RST = 1'b0;
  localparam logic MASK_RST = 1'b0;
  localparam logic [9:0] ENABLE_RST = 10'h000;
  localparam logic [5:0] FLAG_RST = 6'h00;

  // ==========================================================
  // Channel counts
  localparam int KEY_CHANNELS = 10;
  localparam int FLAG_CHANNELS = 6;

  // ==========================================================
  // AHB encodings
  localparam logic [2:0] HSIZE_BYTE = 3'h0;
  localparam logic [2:0] HSIZE_HALF = 3'h1;
  localparam logic HRESP_OKAY = 1'b0;

endpackage

// *** hdl/kii_top.sv ***
`timescale 1ns/1ps
module kii_top #(
  parameter int NCH = kii_pkg::KEY_CHANNELS,
  parameter int NFLAG = kii_pkg::FLAG_CHANNELS
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [NCH-1:0] key_input_pins,
  input wire logic irq_ack,
  output logic key_irq,
  output logic irq
);

  // ==========================================================
  // Elaboration checks
  if (NFLAG < 1 || NFLAG >= NCH || NCH > 16) begin : g_bad
    $error("kii_top: need 1 <= NFLAG < NCH <= 16");
  end

  // ==========================================================
  // State
  typedef struct packed {
    logic [NCH-1:0] sync1;
    logic [NCH-1:0] sync2;
    logic [NCH-1:0] prev;
    logic mode;
    logic pol;
    logic [NCH-1:0] en;
    logic [NFLAG-1:0] flags;
    logic key_irq;
    logic pend;
    logic mask;
    logic irq;
    logic wr_act;
    logic [7:0] wr_addr;
    logic [3:0] wr_be;
    logic [31:0] rdata;
    logic ready;
    logic resp;
  } kii_state_t;

  kii_state_t st_reg;
  kii_state_t st_next;

  logic [NCH-1:0] rise;
  logic [NCH-1:0] fall;
  logic [NCH-1:0] edg;
  logic [NCH-1:0] act;
  logic [NFLAG-1:0] hit;
  logic [NFLAG-1:0] flag_clr;
  logic [31:0] wmask;
  logic pend_w1c;
  logic clr_ev;
  logic upper;
  logic lvl;
  logic pend_set;
  logic addr_ok;

  function automatic logic [3:0] lane_en(
    input logic [2:0] sz,
    input logic [1:0] a
  );
    logic [3:0] r;
    r = 4'hF;
    if (sz == kii_pkg::HSIZE_BYTE) begin
      r = 4'(4'h1 << a);
    end else if (sz == kii_pkg::HSIZE_HALF) begin
      r = a[1] ? 4'hC : 4'h3;
    end
    return r;
  endfunction

  // ==========================================================
  // Next state
  always_comb begin
    st_next = st_reg;
    flag_clr = '0;
    pend_w1c = 1'b0;
    // Two-flop synchroniser, edges compare sync2 to prev
    st_next.sync1 = key_input_pins;
    st_next.sync2 = st_reg.sync1;
    st_next.prev = st_reg.sync2;
    rise = st_reg.sync2 & ~st_reg.prev;
    fall = ~st_reg.sync2 & st_reg.prev;
    edg = st_reg.pol ? rise : fall;
    act = st_reg.pol ? st_reg.sync2 : ~st_reg.sync2;
    hit = edg[NFLAG-1:0] & st_reg.en[NFLAG-1:0];
    wmask = {{8{st_reg.wr_be[3]}}, {8{st_reg.wr_be[2]}},
             {8{st_reg.wr_be[1]}}, {8{st_reg.wr_be[0]}}};

    // Write data phase
    if (st_reg.wr_act) begin
      case (st_reg.wr_addr)
        kii_pkg::OFS_CTRL: begin
          if (st_reg.wr_be[0]) begin
            st_next.mode = hwdata[kii_pkg::MODE_BIT];
            st_next.pol = hwdata[kii_pkg::POL_BIT];
          end
        end
        kii_pkg::OFS_ENABLE: begin
          st_next.en = (st_reg.en & ~wmask[NCH-1:0])
                     | (hwdata[NCH-1:0] & wmask[NCH-1:0]);
        end
        kii_pkg::OFS_FLAG: begin
          // Only zeros act, so ones leave other flags alone
          if (st_reg.wr_be[0]) begin
            flag_clr = ~hwdata[NFLAG-1:0];
          end
        end
        kii_pkg::OFS_PEND: begin
          if (st_reg.wr_be[0]) begin
            pend_w1c = hwdata[kii_pkg::PEND_BIT];
          end
        end
        kii_pkg::OFS_MASK: begin
          if (st_reg.wr_be[0]) begin
            st_next.mask = hwdata[kii_pkg::MASK_BIT];
          end
        end
        default: begin
        end
      endcase
    end

    // A new edge in the clearing cycle keeps its flag
    st_next.flags = (st_reg.flags & ~flag_clr)
                  | (st_reg.mode ? hit : '0);
    clr_ev = st_reg.mode && |(st_reg.flags & flag_clr);
    // Flagless channels count only while still held active
    upper = |(act[NCH-1:NFLAG]
            & st_reg.en[NCH-1:NFLAG]);
    lvl = |(act & st_reg.en);
    if (st_reg.mode) begin
      // Forced low in the clear cycle so any leftover
      // source gives a fresh edge one clock later
      st_next.key_irq = (|st_next.flags | upper)
                      & ~clr_ev;
    end else begin
      // No flags here: software must poll the pin levels
      st_next.key_irq = lvl;
    end

    // Controller pending flag: set wins over clear
    pend_set = st_next.key_irq & ~st_reg.key_irq;
    st_next.pend = pend_set
                 | (st_reg.pend & ~irq_ack & ~pend_w1c);
    st_next.irq = st_next.pend & st_next.mask;

    // Address phase
    // Zero wait states: a read answers in its own data phase
    addr_ok = hsel && htrans[1] && hready;
    st_next.wr_act = addr_ok && hwrite;
    st_next.wr_addr = haddr[7:0];
    st_next.wr_be = lane_en(hsize, haddr[1:0]);
    st_next.rdata = '0;
    if (addr_ok && !hwrite) begin
      case ({haddr[7:2], 2'b00})
        kii_pkg::OFS_CTRL: begin
          st_next.rdata[kii_pkg::MODE_BIT] = st_reg.mode;
          st_next.rdata[kii_pkg::POL_BIT] = st_reg.pol;
        end
        kii_pkg::OFS_ENABLE: begin
          st_next.rdata[NCH-1:0] = st_reg.en;
        end
        kii_pkg::OFS_FLAG: begin
          st_next.rdata[NFLAG-1:0] = st_reg.flags;
        end
        kii_pkg::OFS_PEND: begin
          st_next.rdata[kii_pkg::PEND_BIT] = st_reg.pend;
        end
        kii_pkg::OFS_MASK: begin
          st_next.rdata[kii_pkg::MASK_BIT] = st_reg.mask;
        end
        kii_pkg::OFS_LEVEL: begin
          st_next.rdata[NCH-1:0] = st_reg.sync2;
          st_next.rdata[kii_pkg::LVL_REQ_BIT] = st_reg.key_irq;
        end
        default: begin
        end
      endcase
    end
    st_next.ready = 1'b1;
    st_next.resp = kii_pkg::HRESP_OKAY;
  end

  // ==========================================================
  // Registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      // Synchroniser resets low, so a pin high at reset can
      // look like a rising edge a few cycles after release
      st_reg <= '0;
      st_reg.mode <= kii_pkg::CTRL_MODE_RST;
      st_reg.pol <= kii_pkg::CTRL_POL_RST;
      st_reg.en <= NCH'(kii_pkg::ENABLE_RST);
      st_reg.flags <= NFLAG'(kii_pkg::FLAG_RST);
      st_reg.mask <= kii_pkg::MASK_RST;
      st_reg.ready <= 1'b1;
      st_reg.resp <= kii_pkg::HRESP_OKAY;
    end else begin
      st_reg <= st_next;
    end
  end

  assign hrdata = st_reg.rdata;
  assign hreadyout = st_reg.ready;
  assign hresp = st_reg.resp;
  assign key_irq = st_reg.key_irq;
  assign irq = st_reg.irq;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  logic [NFLAG-1:0] flags_q;
  logic [NFLAG-1:0] flags_nx;
  logic mode_q;
  logic flag_wr_ones;
  assign flags_q = st_reg.flags;
  assign flags_nx = st_next.flags;
  assign mode_q = st_reg.mode;
  assign flag_wr_ones = st_reg.wr_act && st_reg.wr_be[0]
                     && st_reg.wr_addr == kii_pkg::OFS_FLAG
                     && &hwdata[NFLAG-1:0];

  a_level_raise: assert property (
    !mode_q && |(act & st_reg.en) |=> key_irq)
    else $error("level mode request missing");

  a_level_drop: assert property (
    !mode_q && !(|(act & st_reg.en)) |=> !key_irq)
    else $error("level mode request not released");

  a_no_retrigger: assert property (
    !mode_q && key_irq && lvl |=> !pend_set)
    else $error("second request while level held");

  a_flag_latch: assert property (
    mode_q && |hit |=> (flags_q & $past(hit)) == $past(hit))
    else $error("edge did not latch its flag");

  a_flag_drop: assert property (
    clr_ev |=> !key_irq)
    else $error("request not dropped on flag clear");

  a_one_per_edge: assert property (
    mode_q && !(|hit) && !upper && key_irq && !clr_ev
      |=> !pend_set || |hit || upper || !mode_q)
    else $error("extra request without new edge");

  a_reraise: assert property (
    clr_ev && |flags_nx |=> !key_irq ##1
      (key_irq || $past(clr_ev) || !mode_q))
    else $error("pending flag not re-raised in one clock");

  a_upper_follow: assert property (
    mode_q && !clr_ev && flags_nx == '0 |=> key_irq == $past(upper))
    else $error("flagless level not followed");

  a_upper_released: assert property (
    mode_q && flags_nx == '0 && !upper |=> !key_irq)
    else $error("request for released flagless input");

  a_pend_ack: assert property (
    irq_ack && !pend_set |=> !st_reg.pend)
    else $error("pending flag survived acknowledge");

  a_flag_keep: assert property (
    flag_wr_ones |=> ($past(flags_q) & ~flags_q) == '0)
    else $error("writing ones cleared a flag");

  a_irq_gate: assert property (
    irq == (st_reg.pend && st_reg.mask))
    else $error("interrupt output not gated by mask");

  a_edge_select: assert property (
    mode_q && ((st_reg.pol && !(|(st_reg.sync2 & ~st_reg.prev)))
      || (!st_reg.pol && !(|(st_reg.prev & ~st_reg.sync2))))
      |=> (flags_q & ~$past(flags_q)) == '0)
    else $error("flag set by the unselected edge");

  a_disabled_quiet: assert property (
    mode_q && |(edg[NFLAG-1:0] & ~st_reg.en[NFLAG-1:0])
      |=> (flags_q & ~$past(flags_q)
           & ~$past(st_reg.en[NFLAG-1:0])) == '0)
    else $error("disabled channel set a flag");

  a_pend_set: assert property (
    pend_set |=> st_reg.pend)
    else $error("new request lost its pending flag");

  c_level_irq: cover property (!mode_q ##1 $rose(key_irq));
  c_flag_reraise: cover property (clr_ev && |flags_nx ##2 key_irq);
  c_upper_reraise: cover property (
    clr_ev && flags_nx == '0 ##2 key_irq);
  c_ack: cover property (st_reg.pend ##1 irq_ack ##1 !st_reg.pend);
  c_pol_rising: cover property (mode_q && st_reg.pol && |hit);

endmodule

// *** verification/kii_keys.sv ***
`timescale 1ns/1ps
module kii_keys (
  input wire logic hclk,
  input wire logic set_en,
  input wire logic [3:0] set_ch,
  input wire logic set_lvl,
  output logic [9:0] pins
);
  // ==========================================================
  // Switch bank
  // Pull-ups hold every released switch high
  logic [9:0] lvl_reg = 10'h3FF;
  always @(posedge hclk) begin
    if (set_en) begin
      lvl_reg[set_ch] <= set_lvl;
    end
  end
  assign pins = lvl_reg;
endmodule

// *** verification/testbench.sv ***
`timescale 1ns/1ps
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin num_errors++; \
  $display("unexpected t=%0t got=%h exp=%h", $time, a, e); end end
module testbench;
  logic hclk = 1'h0;
  logic hresetn = 1'h0;
  logic hsel = 1'h0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic irq_ack = 1'h0;
  logic set_en = 1'h0;
  logic [3:0] set_ch = 4'h0;
  logic set_lvl = 1'h0;
  logic [31:0] hrdata, r;
  logic hreadyout, hresp, key_irq, irq;
  logic [9:0] pins;
  logic [9:0] pexp = 10'h3FF;
  logic [7:0] ofs [6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h1C};
  int num_errors = 0;
  int compares = 0;
  int ch;
  kii_top i_kii_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .key_input_pins(pins),
    .irq_ack(irq_ack), .key_irq(key_irq), .irq(irq));
  kii_keys i_kii_keys (.hclk(hclk), .set_en(set_en), .set_ch(set_ch),
    .set_lvl(set_lvl), .pins(pins));
  initial begin
    forever #2.5 hclk = ~hclk;
  end
  // ==========================================================
  // Expectations
  function automatic logic [31:0] clr(int c);
    return 32'hFF & ~(32'h1 << c);
  endfunction
  function automatic logic [31:0] lvl(logic k);
    return {15'h0, k, 6'h0, pexp};
  endfunction
  // ==========================================================
  // Drivers
  task automatic bus(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'h1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'h1);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'h1);
    r = hrdata;
    `CHK(hresp, 1'h0)
  endtask
  // Five edges covers the synchroniser plus detect latency
  task automatic key(input int c, input logic v);
    @(posedge hclk);
    set_en <= 1'h1;
    set_ch <= 4'(c);
    set_lvl <= v;
    pexp[c] = v;
    @(posedge hclk);
    set_en <= 1'h0;
    repeat (5) @(posedge hclk);
    #1;
  endtask
  task automatic clrf(input int c, input logic again);
    bus(1'h1, 8'h08, clr(c));
    #1;
    `CHK(key_irq, 1'h0)
    @(posedge hclk);
    #1;
    `CHK(key_irq, again)
  endtask
  task automatic final_report;
    $display("errors=%0d compares=%0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    #100000;
    num_errors++;
    final_report();
  end
  // ==========================================================
  // Scenarios
  initial begin
    void'($urandom(77));
    repeat (6) @(posedge hclk);
    hresetn <= 1'h1;
    bus(1'h1, 8'h1C, $urandom);
    foreach (ofs[i]) begin
      bus(1'h0, ofs[i], 32'h0);
      `CHK(r, 32'h0)
    end
    bus(1'h1, 8'h04, 32'h3FB);
    key(2, 1'h0);
    `CHK(key_irq, 1'h0)
    key(2, 1'h1);
    ch = 3 + $urandom % 7;
    key(ch, 1'h0);
    `CHK(key_irq, 1'h1)
    bus(1'h0, 8'h14, 32'h0);
    `CHK(r, lvl(1'h1))
    bus(1'h1, 8'h0C, 32'h1);
    key(1, 1'h0);
    bus(1'h0, 8'h0C, 32'h0);
    `CHK(r, 32'h0)
    key(ch, 1'h1);
    `CHK(key_irq, 1'h1)
    key(1, 1'h1);
    `CHK(key_irq, 1'h0)
    bus(1'h1, 8'h10, 32'h1);
    key(0, 1'h0);
    `CHK(irq, 1'h1)
    @(posedge hclk);
    irq_ack <= 1'h1;
    @(posedge hclk);
    irq_ack <= 1'h0;
    repeat (2) @(posedge hclk);
    #1;
    `CHK(irq, 1'h0)
    key(0, 1'h1);
    key(1, 1'h0);
    bus(1'h1, 8'h0C, 32'h1);
    @(posedge hclk);
    #1;
    `CHK(irq, 1'h0)
    key(1, 1'h1);
    bus(1'h1, 8'h00, 32'h1);
    repeat (5) @(posedge hclk);
    #1;
    `CHK(key_irq, 1'h1)
    bus(1'h1, 8'h04, 32'h3FF);
    bus(1'h1, 8'h00, 32'h80);
    ch = $urandom % 5;
    key(ch, 1'h0);
    `CHK(key_irq, 1'h1)
    bus(1'h0, 8'h08, 32'h0);
    `CHK(r, 32'h1 << ch)
    key(ch + 1, 1'h0);
    key(6, 1'h0);
    key(ch, 1'h1);
    key(ch + 1, 1'h1);
    bus(1'h1, 8'h08, 32'hFF);
    bus(1'h0, 8'h08, 32'h0);
    `CHK(r, 32'h3 << ch)
    clrf(ch, 1'h1);
    clrf(ch + 1, 1'h1);
    key(6, 1'h1);
    `CHK(key_irq, 1'h0)
    key(ch, 1'h0);
    key(7, 1'h0);
    key(7, 1'h1);
    clrf(ch, 1'h0);
    key(ch, 1'h1);
    key(ch, 1'h0);
    bus(1'h1, 8'h0C, 32'h1);
    clrf(ch, 1'h0);
    key(ch, 1'h1);
    bus(1'h0, 8'h0C, 32'h0);
    `CHK(r, 32'h0)
    bus(1'h1, 8'h00, 32'h81);
    key(ch, 1'h0);
    bus(1'h0, 8'h08, 32'h0);
    `CHK(r, 32'h0)
    key(ch, 1'h1);
    bus(1'h1, 8'h04, 32'h3DF);
    key(5, 1'h0);
    key(5, 1'h1);
    bus(1'h0, 8'h08, 32'h0);
    `CHK(r, 32'h1 << ch)
    final_report();
  end
endmodule
